// [verilog/nvp_pkg.sv]
// Shared constants, opcodes and carrier types for the serial memory slave.
// Assumes a single 50 MHz system clock and a slow serial clock.
package nvp_pkg;

    // ****************************************************
    // Array geometry and protection boundaries
    // ****************************************************
    localparam int ADDR_W = 15;
    localparam int MEM_WORDS = 32768;
    localparam int WR_FIFO_DEPTH = 8;
    localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
    localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

    // ****************************************************
    // Opcodes
    // ****************************************************
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_MEM_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_CLOCK_REG_WRITE = 8'h12;
    localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hc2;
    localparam logic [7:0] OP_NV_STORE = 8'h3c;
    localparam logic [7:0] OP_NV_RECALL = 8'h60;
    localparam logic [7:0] OP_AUTO_SAVE_ON = 8'h59;
    localparam logic [7:0] OP_AUTO_SAVE_OFF = 8'h19;

    // ****************************************************
    // Status register layout and reset values
    // ****************************************************
    localparam int ST_READY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_SERIAL_NUMBER_LOCK_BIT = 6;
    localparam int ST_PIN_PROTECT_ENABLE_BIT = 7;
    localparam logic [7:0] ST_RESET = 8'h00;
    localparam logic [7:0] ST_WRITABLE_MASK = 8'h8c;
    localparam logic [4:0] PIN_SYNC_RESET = 5'h13;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b011,
        ST_DUMMY = 3'b010,
        ST_DOUT = 3'b110,
        ST_DIN = 3'b111,
        ST_IGNORE = 3'b101
    } nvp_state_e;

    typedef enum logic [1:0] {
        LATCH_KEEP = 2'b00,
        LATCH_SET = 2'b01,
        LATCH_CLEAR = 2'b10
    } nvp_latch_e;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } nvp_wr_s;

endpackage

// [verilog/nvp_sync.sv]
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are slow levels, not pulses shorter than two clocks.
`timescale 1ns/1ns
`default_nettype none
module nvp_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= RESET_VAL;
            pinSync <= RESET_VAL;
        end else begin
            stage1_reg <= pinIn;
            pinSync <= stage1_reg;
        end
    end

endmodule // nvp_sync
`default_nettype wire

// [verilog/nvp_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ns
`default_nettype none
module nvp_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wrPtr_reg;
    logic [PW:0] rdPtr_reg;

    wire doPush = inValid & inReady;
    wire doPop = outValid & outReady;
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign inReady = wrPtr_reg != {~rdPtr_reg[PW], rdPtr_reg[PW-1:0]};
    assign outData = store[rdPtr_reg[PW-1:0]];

    always_ff @(posedge clk) begin
        if (doPush) begin
            store[wrPtr_reg[PW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + (PW+1)'(doPush);
            rdPtr_reg <= rdPtr_reg + (PW+1)'(doPop);
        end
    end

endmodule // nvp_fifo
`default_nettype wire

// [verilog/nvp_spi_slave.sv]
// Serial slave front end for a 32K x 8 battery-free SRAM with write protection.
// Assumes the serial clock is at most clk/8, so every pin edge is seen after sync.
//
// What this block does
// - Data-modifying instructions run only while the write latch is set.
// - Write latch is cleared after reset.
// - Write instruction with latch clear is ignored until chip select rises.
// - Set-latch instruction sets the write latch.
// - Any write-type instruction clears the write latch at chip select rise, except a memory write refused while busy.
// - Clear-latch instruction clears the latch when chip select rises.
// - Block protect bits pick none, top quarter, upper half or all.
// - Protected addresses stay readable and are never written.
// - Pin low with pin-protect enable rejects status writes.
// - Pin-protect enable clear makes the pin level irrelevant.
// - Pin falling mid-transfer does not block that status write.
// - Memory read and write are refused while store or recall runs.
// - Read takes opcode, two address bytes, then shifts data MSB first.
// - Read address increments per byte and wraps to zero.
// - Fast read has a dummy byte before the data stream.
// - Chip select high ends a fast read at once.
// - Write takes opcode, two address bytes, then data bytes.
// - Write address increments per byte and wraps to zero.
// - Burst write skips protected addresses but keeps counting.
// - Ready bit reads one while store or recall is busy.
// - Status write changes only bits 2, 3, 6 and 7.
`timescale 1ns/1ns
`default_nettype none
module nvp_spi_slave
    import nvp_pkg::*;
#(
    parameter int MEM_DEPTH = MEM_WORDS,
    parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic csNPin,
    input wire logic sckPin,
    input wire logic siPin,
    input wire logic wpNPin,
    input wire logic hwStoreBusyPinN,
    input wire logic storeBusy,
    output logic soOut,
    output logic soOe,
    output logic [7:0] statusOut,
    output logic [7:0] specialCmd,
    output logic specialStrobe
);

    // ****************************************************
    // Pin synchronisation and edge detection
    // ****************************************************
    logic [4:0] pinSync;
    logic csPrev_reg;
    logic sckPrev_reg;

    nvp_sync #(
        .WIDTH(5),
        .RESET_VAL(PIN_SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pinIn({csNPin, sckPin, siPin, wpNPin, hwStoreBusyPinN}),
        .pinSync(pinSync)
    );

    wire csNS = pinSync[4];
    wire sckS = pinSync[3];
    wire siS = pinSync[2];
    wire wpNS = pinSync[1];
    wire hsbNS = pinSync[0];

    wire csActive = !csNS;
    wire csFall = !csNS & csPrev_reg;
    wire csRise = csNS & !csPrev_reg;
    wire sckRise = sckS & !sckPrev_reg & csActive;
    wire sckFall = !sckS & sckPrev_reg & csActive;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csPrev_reg <= 1'b1;
            sckPrev_reg <= 1'b0;
        end else begin
            csPrev_reg <= csNS;
            sckPrev_reg <= sckS;
        end
    end

    // ****************************************************
    // State and shift registers
    // ****************************************************
    nvp_state_e state_reg, state_next;
    logic [2:0] bitCnt_reg;
    logic [6:0] inShift_reg;
    logic [7:0] opcode_reg;
    logic [14:0] addr_reg;
    logic addrLow_reg;
    logic [2:0] outCnt_reg;
    logic [6:0] outShift_reg;
    logic wpLowAtStart_reg;
    nvp_latch_e latchAction_reg;
    logic specialPend_reg;
    logic [7:0] status_reg;
    logic pendValid_reg;
    nvp_wr_s pendData_reg;
    logic [7:0] memData_reg;

    // Input is sampled on the rising clock edge only
    wire byteDone = sckRise & (bitCnt_reg == 3'h7);
    wire [7:0] byteIn = {inShift_reg, siS};

    // ****************************************************
    // Opcode decode
    // ****************************************************
    wire isRead = byteIn == OP_MEM_READ;
    wire isFast = byteIn == OP_MEM_FAST_READ;
    wire isWrite = byteIn == OP_MEM_WRITE;
    wire isStRead = byteIn == OP_STATUS_READ;
    wire isStWrite = byteIn == OP_STATUS_WRITE;
    wire isSetLatch = byteIn == OP_SET_WRITE_LATCH;
    wire isClrLatch = byteIn == OP_CLEAR_WRITE_LATCH;
    wire isSpecial = (byteIn == OP_NV_STORE) | (byteIn == OP_NV_RECALL)
        | (byteIn == OP_AUTO_SAVE_ON) | (byteIn == OP_AUTO_SAVE_OFF);
    wire isOtherWr = (byteIn == OP_CLOCK_REG_WRITE) | (byteIn == OP_SERIAL_NUMBER_WRITE);
    wire needsLatch = isWrite | isStWrite | isSpecial | isOtherWr;
    wire isMemOp = isRead | isFast | isWrite;
    wire latchSet = status_reg[ST_LATCH_BIT];
    wire busyNow = storeBusy | !hsbNS;
    wire opDone = (state_reg == ST_OPCODE) & byteDone;
    wire refuseLatch = needsLatch & !latchSet;
    wire refuseBusy = isMemOp & busyNow;
    wire opStWrite = opcode_reg == OP_STATUS_WRITE;
    wire opFast = opcode_reg == OP_MEM_FAST_READ;
    wire opWrite = opcode_reg == OP_MEM_WRITE;
    wire opStRead = opcode_reg == OP_STATUS_READ;

    // ****************************************************
    // Block protection decode
    // ****************************************************
    wire [1:0] blockProtect = status_reg[3:2];
    wire protQuarter = addr_reg >= PROT_QUARTER_BASE;
    wire protHalf = addr_reg >= PROT_HALF_BASE;
    // Protected range by block_protect_hi/lo
    wire addrProtected = (blockProtect == 2'b11)
        | ((blockProtect == 2'b10) & protHalf)
        | ((blockProtect == 2'b01) & protQuarter);
    // Hardware lock uses the pin level caught at chip select fall
    wire stLocked = wpLowAtStart_reg & status_reg[ST_PIN_PROTECT_ENABLE_BIT];
    wire dinByte = (state_reg == ST_DIN) & byteDone;
    wire stWriteOk = dinByte & opStWrite & !stLocked;
    // Protected bytes are dropped but the address still advances
    wire memPush = dinByte & opWrite & !addrProtected;
    wire outLoad = (state_reg == ST_DOUT) & sckFall & (outCnt_reg == 3'h0);
    wire [7:0] outSrc = opStRead ? status_reg : memData_reg;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (csFall) begin
                    state_next = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (byteDone) begin
                    if (refuseLatch | refuseBusy) begin
                        state_next = ST_IGNORE;
                    end else if (isMemOp) begin
                        state_next = ST_ADDR;
                    end else if (isStRead) begin
                        state_next = ST_DOUT;
                    end else if (isStWrite) begin
                        state_next = ST_DIN;
                    end else begin
                        state_next = ST_IGNORE;
                    end
                end
            end
            ST_ADDR: begin
                if (byteDone & addrLow_reg) begin
                    if (opFast) begin
                        state_next = ST_DUMMY;
                    end else if (opWrite) begin
                        state_next = ST_DIN;
                    end else begin
                        state_next = ST_DOUT;
                    end
                end
            end
            ST_DUMMY: begin
                if (byteDone) begin
                    state_next = ST_DOUT;
                end
            end
            ST_DOUT, ST_DIN, ST_IGNORE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Chip select high ends any transfer at once
        if (!csActive) begin
            state_next = ST_IDLE;
        end
    end

    // ****************************************************
    // Serial input side
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 3'h0;
            inShift_reg <= 7'h00;
            opcode_reg <= 8'h00;
            addrLow_reg <= 1'b0;
            wpLowAtStart_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (csFall) begin
                bitCnt_reg <= 3'h0;
                addrLow_reg <= 1'b0;
                wpLowAtStart_reg <= !wpNS;
            end else if (sckRise) begin
                bitCnt_reg <= bitCnt_reg + 3'h1;
                inShift_reg <= byteIn[6:0];
            end
            if (opDone) begin
                opcode_reg <= byteIn;
            end
            if ((state_reg == ST_ADDR) & byteDone) begin
                addrLow_reg <= 1'b1;
            end
        end
    end

    // ****************************************************
    // Address counter
    // ****************************************************
    // Natural 15-bit wrap takes the last address back to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= 15'h0000;
        end else if ((state_reg == ST_ADDR) & byteDone & !addrLow_reg) begin
            addr_reg <= {byteIn[6:0], addr_reg[7:0]};
        end else if ((state_reg == ST_ADDR) & byteDone) begin
            addr_reg <= {addr_reg[14:8], byteIn};
        end else if (dinByte & opWrite) begin
            addr_reg <= addr_reg + 15'h0001;
        end else if (outLoad & !opStRead) begin
            addr_reg <= addr_reg + 15'h0001;
        end
    end

    // ****************************************************
    // Serial output side
    // ****************************************************
    // Data changes on falling edges; input is ignored meanwhile
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outCnt_reg <= 3'h0;
            outShift_reg <= 7'h00;
            soOut <= 1'b0;
            soOe <= 1'b0;
        end else begin
            soOe <= (state_next == ST_DOUT);
            if (state_reg != ST_DOUT) begin
                outCnt_reg <= 3'h0;
            end else if (sckFall) begin
                outCnt_reg <= outCnt_reg + 3'h1;
                if (outLoad) begin
                    soOut <= outSrc[7];
                    outShift_reg <= outSrc[6:0];
                end else begin
                    soOut <= outShift_reg[6];
                    outShift_reg <= {outShift_reg[5:0], 1'b0};
                end
            end
        end
    end

    // ****************************************************
    // Status register and write latch
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= ST_RESET;
            latchAction_reg <= LATCH_KEEP;
        end else begin
            status_reg[ST_READY_BIT] <= busyNow;
            if (csFall) begin
                latchAction_reg <= LATCH_KEEP;
            end else if (opDone & isSetLatch) begin
                latchAction_reg <= LATCH_SET;
            end else if (opDone & isClrLatch) begin
                latchAction_reg <= LATCH_CLEAR;
            end else if (opDone & needsLatch & latchSet & !refuseBusy) begin
                latchAction_reg <= LATCH_CLEAR;
            end
            if (csRise & (latchAction_reg == LATCH_SET)) begin
                status_reg[ST_LATCH_BIT] <= 1'b1;
            end else if (csRise & (latchAction_reg == LATCH_CLEAR)) begin
                status_reg[ST_LATCH_BIT] <= 1'b0;
            end
            if (stWriteOk) begin
                // Lock bit can be set once and never cleared
                status_reg[3:2] <= byteIn[3:2];
                status_reg[ST_PIN_PROTECT_ENABLE_BIT] <= byteIn[7];
                status_reg[ST_SERIAL_NUMBER_LOCK_BIT] <=
                    status_reg[ST_SERIAL_NUMBER_LOCK_BIT] | byteIn[6];
            end
        end
    end

    assign statusOut = status_reg;

    // ****************************************************
    // Special instruction hand-off
    // ****************************************************
    // Fires only at chip select rise, so a cut-short opcode never triggers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            specialPend_reg <= 1'b0;
            specialCmd <= 8'h00;
            specialStrobe <= 1'b0;
        end else begin
            specialStrobe <= csRise & specialPend_reg;
            if (csFall) begin
                specialPend_reg <= 1'b0;
            end else if (opDone & isSpecial & latchSet) begin
                specialPend_reg <= 1'b1;
                specialCmd <= byteIn;
            end
        end
    end

    // ****************************************************
    // Write buffer and memory array
    // ****************************************************
    // A held byte waits for space; only a serial clock far above spec overruns it
    logic fifoInReady;
    logic fifoOutValid;
    nvp_wr_s fifoOut;
    wire drainReady = state_reg != ST_DOUT;
    wire memWe = fifoOutValid & drainReady;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pendValid_reg <= 1'b0;
            pendData_reg <= '0;
        end else if (memPush) begin
            pendValid_reg <= 1'b1;
            pendData_reg <= '{addr: addr_reg, data: byteIn};
        end else if (fifoInReady) begin
            pendValid_reg <= 1'b0;
        end
    end

    nvp_fifo #(
        .WIDTH($bits(nvp_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(pendValid_reg),
        .inReady(fifoInReady),
        .inData(pendData_reg),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(fifoOut)
    );

    logic [7:0] mem [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[fifoOut.addr] <= fifoOut.data;
        end
        memData_reg <= mem[addr_reg];
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_set_issued;
        opDone && isSetLatch;
    endsequence

    sequence s_set_applied;
        csRise && latchAction_reg == LATCH_SET;
    endsequence

    a_latch_set_seen: assert property (
        s_set_issued |=> latchAction_reg == LATCH_SET)
        else $error("set-latch was not recorded");

    a_latch_set_apply: assert property (
        s_set_applied |=> latchSet)
        else $error("set-latch did not set the write latch");

    a_latch_clear_cmd: assert property (
        opDone && isClrLatch |=> latchAction_reg == LATCH_CLEAR)
        else $error("clear-latch was not recorded");

    a_refused_no_latch: assert property (
        opDone && needsLatch && !latchSet |=> state_reg == ST_IGNORE && !soOe)
        else $error("write instruction ran with latch clear");

    a_write_needs_latch: assert property (
        memPush |-> latchAction_reg == LATCH_CLEAR)
        else $error("memory byte queued without latch");

    a_latch_done_clear: assert property (
        csRise && latchAction_reg == LATCH_CLEAR |=> !latchSet ##1 !latchSet)
        else $error("latch still set after write instruction");

    a_protect_no_store: assert property (
        dinByte && opWrite && addrProtected |=> !pendValid_reg || $stable(pendData_reg))
        else $error("protected address queued for write");

    a_status_locked: assert property (
        dinByte && opStWrite && stLocked |=> $stable(status_reg[7:2]))
        else $error("status changed while pin protection active");

    a_busy_refuses_mem: assert property (
        opDone && isMemOp && busyNow |=> state_reg == ST_IGNORE [*2])
        else $error("memory instruction ran during store");

    a_read_wrap: assert property (
        outLoad && !opStRead && addr_reg == 15'h7fff |=> addr_reg == 15'h0000)
        else $error("read address did not wrap");

    a_cs_ends_read: assert property (
        state_reg == ST_DOUT && !csActive |=> !soOe && state_reg == ST_IDLE)
        else $error("output still driven after chip select rise");

endmodule // nvp_spi_slave
`default_nettype wire

// [verification/nvp_host.sv]
// Host serial master model for the memory slave pins.
// Assumes a 50 MHz bench clock; serial clock is clk/20, mode 0 or 3.
`timescale 1ns/1ns
`default_nettype none
module nvp_host (
    input wire logic clk,
    output logic csN,
    output logic sck,
    output logic si,
    input wire logic so
);
    // Clock idle level: 0 for mode 0, 1 for mode 3
    logic cpol = 1'b0;
    // Steps land just after the edge so pins never race the sampler
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Each frame starts on a fresh fall
    task automatic cs(input logic v);
        if (!v) sck = cpol;
        w(6);
        csN = v;
        if (v) si = ~si; // Released line must not hold its last value
        w(6);
    endtask
    // MSB first, 2.5 MHz, well under the read limit
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (cpol) sck = 1'b0;
            si = tx[i];
            w(10);
            sck = 1'b1;
            rx[i] = so;
            w(10);
            if (!cpol) sck = 1'b0;
        end
    endtask
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
endmodule // nvp_host
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the serial memory slave.
// Assumes the host model drives all serial pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import nvp_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wpN = 1'b1;
    logic busy = 1'b0;
    logic hsbN = 1'b1;
    logic csN, sck, si, so, soOe, stb;
    logic [7:0] st, rxd, spc;
    logic [7:0] strobes = 8'h00;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    nvp_spi_slave i_nvp_spi_slave (.clk(clk), .resetn(resetn), .csNPin(csN), .sckPin(sck),
        .siPin(si), .wpNPin(wpN), .hwStoreBusyPinN(hsbN), .storeBusy(busy), .soOut(so),
        .soOe(soOe), .statusOut(st), .specialCmd(spc), .specialStrobe(stb));
    // A released data line shows the inverse of its last bit
    wire soLine = soOe ? so : ~so;
    nvp_host i_nvp_host (.clk(clk), .csN(csN), .sck(sck), .si(si), .so(soLine));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic sb(input logic [7:0] b);
        i_nvp_host.xb(b, rxd);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input bit hasData);
        i_nvp_host.cs(1'b0);
        sb(op);
        if (hasData) sb(d);
        i_nvp_host.cs(1'b1);
    endtask
    // Top address bit set on purpose, it must be ignored
    task automatic go(input logic [7:0] op, input logic [14:0] a);
        i_nvp_host.cs(1'b0);
        sb(op);
        sb({1'b1, a[14:8]});
        sb(a[7:0]);
    endtask
    task automatic mwr(input logic [14:0] a, input logic [15:0] d, input int n, input bit en);
        if (en) cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        go(OP_MEM_WRITE, a);
        for (int i = 0; i < n; i++) sb(d[15-8*i -: 8]);
        i_nvp_host.cs(1'b1);
    endtask
    task automatic mrd(input logic [7:0] op, input logic [14:0] a, input logic [15:0] e,
        input int n);
        go(op, a);
        if (op == OP_MEM_FAST_READ) sb(8'hff);
        for (int i = 0; i < n; i++) begin
            sb(8'h00);
            chk("mem", e[15-8*i -: 8], rxd);
        end
        i_nvp_host.cs(1'b1);
        chk("so enable", 8'h00, {7'h00, soOe});
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Tests need about 13000 cycles
    always @(posedge clk) begin
        cyc++;
        if (stb) strobes = strobes + 8'h01;
        if (cyc == 40000) begin
            mismatches++;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 resetn = 1'b1;
        i_nvp_host.w(4);
        chk("status", 8'h00, st);
        mwr(15'h0010, 16'h5a00, 1, 1'b1);
        chk("status", 8'h00, st);
        mwr(15'h0010, 16'ha500, 1, 1'b0);
        mrd(OP_MEM_READ, 15'h0010, 16'h5a00, 1);
        $display("test latch done");
        mwr(15'h7fff, 16'h1122, 2, 1'b1);
        mwr(15'h5fff, 16'h0102, 2, 1'b1);
        mrd(OP_MEM_READ, 15'h7fff, 16'h1122, 2);
        i_nvp_host.cpol = 1'b1;
        mrd(OP_MEM_FAST_READ, 15'h5fff, 16'h0102, 2);
        i_nvp_host.cpol = 1'b0;
        $display("test burst done");
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        chk("status", 8'h02, st);
        cmd(OP_STATUS_WRITE, 8'h37, 1'b1);
        chk("status", 8'h04, st);
        mwr(15'h5fff, 16'h3344, 2, 1'b1);
        mrd(OP_MEM_READ, 15'h5fff, 16'h3302, 2);
        $display("test protect done");
        wpN = 1'b0;
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        cmd(OP_STATUS_WRITE, 8'h08, 1'b1);
        chk("status", 8'h08, st);
        wpN = 1'b1;
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        i_nvp_host.cs(1'b0);
        sb(OP_STATUS_WRITE);
        wpN = 1'b0;
        sb(8'h84);
        i_nvp_host.cs(1'b1);
        chk("status", 8'h84, st);
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        cmd(OP_STATUS_WRITE, 8'h00, 1'b1);
        chk("status", 8'h84, st);
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        cmd(OP_CLEAR_WRITE_LATCH, 8'h00, 1'b0);
        chk("status", 8'h84, st);
        i_nvp_host.cs(1'b0);
        sb(OP_STATUS_READ);
        sb(8'h00);
        chk("status read", 8'h84, rxd);
        i_nvp_host.cs(1'b1);
        busy = 1'b1;
        i_nvp_host.w(3);
        chk("status", 8'h85, st);
        $display("test wp done");
        busy = 1'b0;
        hsbN = 1'b0;
        mwr(15'h0010, 16'ha500, 1, 1'b1);
        chk("status", 8'h87, st);
        hsbN = 1'b1;
        mrd(OP_MEM_READ, 15'h0010, 16'h5a00, 1);
        cmd(OP_CLEAR_WRITE_LATCH, 8'h00, 1'b0);
        cmd(OP_NV_RECALL, 8'h00, 1'b0);
        cmd(OP_SET_WRITE_LATCH, 8'h00, 1'b0);
        cmd(OP_NV_STORE, 8'h00, 1'b0);
        chk("special", OP_NV_STORE, spc);
        chk("strobes", 8'h01, strobes);
        chk("status", 8'h84, st);
        $display("test special done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
